// [core/cascaded_irq_pair.sv]
// Cascaded pair of interrupt controllers with NMI and SMI paths
`timescale 1ns/1ns
module cascaded_irq_pair (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire irq_pair_pkg::sourceReq_t onboardReq,
    input wire logic [15:0] sourceEnable,
    input wire logic [15:0] expansionReq,
    input wire logic legacyBusIrq2,
    input wire logic channelCheck,
    input wire logic smiRequest,
    input wire irq_pair_pkg::cfgWrite_t cfgWrite,
    input wire logic ackReq,
    output logic intReq,
    output irq_pair_pkg::ackResp_t ackResp,
    output logic nmiOut,
    output logic [7:0] nmiVector,
    output logic smiOut
);
    logic [irq_pair_pkg::SYNC_WIDTH-1:0] rawIn;
    logic [irq_pair_pkg::SYNC_WIDTH-1:0] syncA;
    logic [irq_pair_pkg::SYNC_WIDTH-1:0] syncB;
    logic [irq_pair_pkg::SYNC_WIDTH-1:0] syncC;
    logic [irq_pair_pkg::SYNC_WIDTH-1:0] filtered;
    logic [irq_pair_pkg::SYNC_WIDTH-1:0] next_filtered;
    logic [15:0] legacyLine;
    logic [15:0] effEnable;
    logic [15:0] onboardGated;
    logic [15:0] lineLevel;
    logic [15:0] mask;
    logic remap9;
    logic [7:0] masterReq;
    logic slaveActive;
    logic [2:0] slaveIndex;
    logic [7:0] slaveVecRaw;
    logic [7:0] slaveVec;
    logic masterActive;
    logic [2:0] masterIndex;
    logic [7:0] masterVec;
    logic cascadeAck;
    logic legacyHit;
    logic [7:0] next_vector;

    // Fixed sources stay enabled whatever the configuration says
    assign effEnable = sourceEnable | irq_pair_pkg::FIXED_ENABLE;
    // Disabled on-board sources let go so add-in cards may use the line
    assign onboardGated = onboardReq & effEnable;
    // Add-in requests share the line by OR; they must pick vacant lines
    // Legacy bus line 2 lands in the secondary slot of line 9
    assign legacyLine = 16'(legacyBusIrq2) <<
        (irq_pair_pkg::UNIT_WIDTH + int'(irq_pair_pkg::LEGACY_SLAVE_INPUT));
    // Bit 2 is the cascade slot, so nothing outside may drive it
    assign rawIn[15:0] = (onboardGated | expansionReq |
        legacyLine) &
        irq_pair_pkg::CASCADE_CLEAR;
    assign rawIn[irq_pair_pkg::NMI_BIT] = channelCheck;
    assign rawIn[irq_pair_pkg::SMI_BIT] = smiRequest;

    // A bit changes only when the second and third stage agree
    assign next_filtered = (~(syncB ^ syncC) & syncC) |
        ((syncB ^ syncC) & filtered);

    // Three-stage capture of pins from outside the clock domain
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            syncA <= '0;
            syncB <= '0;
            syncC <= '0;
            filtered <= '0;
        end else begin
            syncA <= rawIn;
            syncB <= syncA;
            syncC <= syncB;
            filtered <= next_filtered;
        end
    end

    assign lineLevel = filtered[15:0];

    // Masks come up all set; each firmware write loads all sixteen at once
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mask <= irq_pair_pkg::MASK_RESET;
            remap9 <= 1'b0;
        end else if (cfgWrite.wr) begin
            mask <= cfgWrite.mask;
            remap9 <= cfgWrite.remap9;
        end
    end

    // Secondary unit: lines 8 to 15
    pic_unit slaveUnit (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .req(lineLevel[15:8]),
        .mask(mask[15:8]),
        .base(irq_pair_pkg::SLAVE_BASE),
        .active(slaveActive),
        .index(slaveIndex),
        .vector(slaveVecRaw)
    );

    // Secondary output takes the cascade slot of the primary
    assign masterReq = {lineLevel[7:3], slaveActive, lineLevel[1:0]};

    // Primary unit: lines 0 to 7
    pic_unit masterUnit (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .req(masterReq),
        .mask(mask[7:0]),
        .base(irq_pair_pkg::MASTER_BASE),
        .active(masterActive),
        .index(masterIndex),
        .vector(masterVec)
    );

    // Acknowledge steering between the two units
    assign cascadeAck = masterActive &&
        (masterIndex == irq_pair_pkg::CASCADE_INPUT);
    assign legacyHit = remap9 &&
        (slaveIndex == irq_pair_pkg::LEGACY_SLAVE_INPUT);
    assign slaveVec = legacyHit ? irq_pair_pkg::LEGACY_VECTOR
        : slaveVecRaw;
    assign next_vector = cascadeAck ? slaveVec : masterVec;

    // Level outputs follow the filtered state one cycle later
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            intReq <= 1'b0;
            nmiOut <= 1'b0;
            smiOut <= 1'b0;
            nmiVector <= irq_pair_pkg::NMI_VECTOR;
        end else begin
            intReq <= masterActive;
            nmiOut <= filtered[irq_pair_pkg::NMI_BIT];
            smiOut <= filtered[irq_pair_pkg::SMI_BIT];
            nmiVector <= irq_pair_pkg::NMI_VECTOR;
        end
    end

    // Vector answer one cycle after the acknowledge pulse
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ackResp <= '0;
        end else begin
            ackResp.valid <= ackReq;
            ackResp.cascade <= ackReq && cascadeAck;
            ackResp.vector <= ackReq ? next_vector : 8'h00;
        end
    end

    cascade_path_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        slaveActive && !mask[2] |=> intReq)
    else $error("secondary request did not reach the processor");

    masked_quiet_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        (mask == irq_pair_pkg::MASK_RESET) |=> !intReq)
    else $error("request raised while all lines masked");

    master_vector_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        ackReq && masterActive && !cascadeAck |=>
            ackResp.valid && !ackResp.cascade &&
            ackResp.vector == (8'h08 + 8'($past(masterIndex))))
    else $error("primary vector wrong");

    slave_vector_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        ackReq && cascadeAck && !legacyHit |=>
            ackResp.vector == (8'h70 + 8'($past(slaveIndex))))
    else $error("secondary vector wrong");

    legacy_vector_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        ackReq && cascadeAck && legacyHit |=> ackResp.vector == 8'h0A)
    else $error("legacy line 9 not served at 0Ah");

    cascade_flag_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        ackReq |=> ackResp.cascade == $past(cascadeAck))
    else $error("cascade flag does not match primary choice");

    nmi_path_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        channelCheck [*6] |=> nmiOut && nmiVector == 8'h02)
    else $error("channel check did not raise NMI");

    smi_path_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        smiRequest [*6] |=> smiOut)
    else $error("SMI suppressed");

    release_line_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        (!sourceEnable[6] && !expansionReq[6]) [*6] |=> !lineLevel[6])
    else $error("disabled source still holds its line");

    // Fixed sources get through the filter whatever the enables say
    fixed_timer_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        onboardReq.timer0 [*6] |=> lineLevel[0])
    else $error("timer line did not reach input zero");

    legacy_entry_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        legacyBusIrq2 [*6] |=> lineLevel[9])
    else $error("legacy line 2 did not reach input nine");

    // Secondary requests outrank primary inputs three to seven
    cascade_slot_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        slaveActive && !mask[2] &&
            ((lineLevel[1:0] & ~mask[1:0]) == 2'h0) |-> cascadeAck)
    else $error("primary input beat the cascade slot");

    ack_idle_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        !ackReq |=> !ackResp.valid && !ackResp.cascade &&
            ackResp.vector == 8'h00)
    else $error("answer shown without an acknowledge");
endmodule

// [core/irq_pair_pkg.sv]
// Shared constants and carrier types for the cascaded interrupt pair
package irq_pair_pkg;
    localparam int LINE_COUNT = 16;
    localparam int UNIT_WIDTH = 8;
    localparam int SYNC_WIDTH = 18;
    localparam logic [2:0] CASCADE_INPUT = 3'h2;
    localparam logic [2:0] LEGACY_SLAVE_INPUT = 3'h1;
    localparam logic [7:0] MASTER_BASE = 8'h08;
    localparam logic [7:0] SLAVE_BASE = 8'h70;
    localparam logic [7:0] LEGACY_VECTOR = 8'h0A;
    localparam logic [7:0] NMI_VECTOR = 8'h02;
    localparam logic [15:0] MASK_RESET = 16'hFFFF;
    // Fixed on-board sources: lines 0, 1, 8, 13 and 14 cannot be disabled
    localparam logic [15:0] FIXED_ENABLE = 16'h6103;
    localparam logic [15:0] CASCADE_CLEAR = 16'hFFFB;
    localparam int NMI_BIT = 16;
    localparam int SMI_BIT = 17;

    // On-board request sources, one field per request line, line 15 first
    typedef struct packed {
        logic disk1;
        logic disk0;
        logic coproc;
        logic mouse;
        logic slot11;
        logic fieldbus;
        logic video;
        logic rtc;
        logic parallel;
        logic floppy;
        logic sound;
        logic serial1;
        logic serial2;
        logic spare2;
        logic keyboardFull;
        logic timer0;
    } sourceReq_t;

    // Configuration write from the firmware side
    typedef struct packed {
        logic wr;
        logic remap9;
        logic [15:0] mask;
    } cfgWrite_t;

    // Answer to an acknowledge cycle
    typedef struct packed {
        logic valid;
        logic cascade;
        logic [7:0] vector;
    } ackResp_t;
endpackage

// [core/pic_unit.sv]
// One eight-input fixed-priority controller slice
`timescale 1ns/1ns
module pic_unit (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [7:0] req,
    input wire logic [7:0] mask,
    input wire logic [7:0] base,
    output logic active,
    output logic [2:0] index,
    output logic [7:0] vector
);
    // Lowest numbered set bit wins; no bit set gives 7 (spurious slot)
    function automatic logic [2:0] firstSet(input logic [7:0] bits);
        logic [2:0] pick;
        pick = 3'h7;
        for (int i = 7; i >= 0; i--) begin
            if (bits[i]) begin
                pick = 3'(i);
            end
        end
        return pick;
    endfunction

    logic [7:0] pending;

    // Masked lines take no part in arbitration
    assign pending = req & ~mask;
    assign active = |pending;
    assign index = firstSet(pending);
    // Bases are aligned to eight, so OR equals add
    assign vector = base | {5'h00, index};

    prio_order_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        active |-> pending[index] &&
            ((pending & ((8'h01 << index) - 8'h01)) == 8'h00))
    else $error("higher priority line pending but not chosen");

    mask_gate_a:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        (mask == 8'hFF) |-> !active)
    else $error("fully masked slice reports a request");
endmodule

// [dv/cascaded_irq_pair_bench.sv]
// Self-checking bench for the cascaded interrupt pair
`timescale 1ns/1ns
module cascaded_irq_pair_bench;
    typedef struct packed {
        logic [15:0] src;
        logic [15:0] en;
        logic [15:0] ext;
        logic [15:0] mask;
        logic irq;
        logic [7:0] vec;
        logic casc;
    } row_t;
    // Source, enable, add-in, mask, then the expected answer
    localparam row_t ROWS [11] = '{
        '{16'h0001,16'h0000,16'h0000,16'hFFFE,1'h1,8'h08,1'h0},
        '{16'h0081,16'h0080,16'h0000,16'h0000,1'h1,8'h08,1'h0},
        '{16'h0080,16'h0080,16'h0000,16'h0000,1'h1,8'h0F,1'h0},
        '{16'h0108,16'h0008,16'h0000,16'h0000,1'h1,8'h70,1'h1},
        '{16'h8000,16'h8000,16'h0200,16'h0000,1'h1,8'h71,1'h1},
        '{16'h2000,16'h0000,16'h0000,16'hDFFB,1'h1,8'h75,1'h1},
        '{16'h4000,16'h0000,16'h0000,16'hBFFB,1'h1,8'h76,1'h1},
        '{16'h8000,16'h8000,16'h0000,16'h7FFB,1'h1,8'h77,1'h1},
        '{16'h0008,16'h0000,16'h0000,16'h0000,1'h0,8'h00,1'h0},
        '{16'h0100,16'h0000,16'h0000,16'h0004,1'h0,8'h00,1'h0},
        '{16'h0000,16'h0000,16'h0800,16'h0000,1'h1,8'h73,1'h1}
    };
    logic sysClk = 1'h0;
    logic sysRst = 1'h1;
    irq_pair_pkg::sourceReq_t onboardReq = '0;
    logic [15:0] sourceEnable = 16'h0000;
    logic [15:0] expansionReq = 16'h0000;
    logic legacyBusIrq2 = 1'h0;
    logic channelCheck = 1'h0;
    logic smiRequest = 1'h0;
    irq_pair_pkg::cfgWrite_t cfgWrite = '0;
    logic ackGo = 1'h0;
    logic ackReq, intReq, nmiOut, smiOut, gotCascade, gotValid;
    logic [7:0] nmiVector, gotVector;
    irq_pair_pkg::ackResp_t ackResp;
    int failCount = 0;
    int checks = 0;
    int cycles = 0;

    always #4 sysClk = ~sysClk;

    cascaded_irq_pair u_cascaded_irq_pair (.sys_clk(sysClk),
        .sys_rst(sysRst), .onboardReq(onboardReq),
        .sourceEnable(sourceEnable), .expansionReq(expansionReq),
        .legacyBusIrq2(legacyBusIrq2), .channelCheck(channelCheck),
        .smiRequest(smiRequest), .cfgWrite(cfgWrite), .ackReq(ackReq),
        .intReq(intReq), .ackResp(ackResp), .nmiOut(nmiOut),
        .nmiVector(nmiVector), .smiOut(smiOut));
    irq_core_model u_irq_core_model (.sys_clk(sysClk), .sys_rst(sysRst),
        .ackGo(ackGo), .ackResp(ackResp), .ackReq(ackReq),
        .gotVector(gotVector), .gotCascade(gotCascade),
        .gotValid(gotValid));

    task automatic check_bit(string name, logic exp, logic got);
        checks++;
        if (got !== exp) begin
            failCount++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task automatic check_byte(string name, logic [7:0] exp, logic [7:0] got);
        checks++;
        if (got !== exp) begin
            failCount++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    // Pins need four edges to pass the filter and five to reach intReq, so settle for nine
    task automatic configure(logic [15:0] mask, logic remap);
        @(posedge sysClk);
        cfgWrite <= '{wr: 1'h1, remap9: remap, mask: mask};
        @(posedge sysClk);
        cfgWrite.wr <= 1'h0;
        repeat (7) @(posedge sysClk);
    endtask
    // Answer sampled at the falling edge, once the model has settled
    task automatic acknowledge(logic [7:0] exp, logic casc);
        int n;
        ackGo <= 1'h1;
        @(posedge sysClk);
        ackGo <= 1'h0;
        repeat (2) @(posedge sysClk);
        n = 0;
        while (gotValid !== 1'h1 && n < 10) begin
            @(negedge sysClk);
            n++;
        end
        check_bit("answer", 1'h1, gotValid);
        check_byte("vector", exp, gotVector);
        check_bit("cascade", casc, gotCascade);
        @(posedge sysClk);
    endtask
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", checks, failCount);
        if (failCount == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Cut a hang short well past the expected run length
    always @(posedge sysClk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            failCount++;
            finish_test();
        end
    end

    initial begin
        repeat (10) @(posedge sysClk);
        sysRst <= 1'h0;
        onboardReq <= 16'h0001;
        repeat (8) @(posedge sysClk);
        check_bit("intReq", 1'h0, intReq);
        check_byte("nmiVector", 8'h02, nmiVector);
        for (int i = 0; i < 11; i++) begin
            onboardReq <= ROWS[i].src;
            sourceEnable <= ROWS[i].en;
            expansionReq <= ROWS[i].ext;
            configure(ROWS[i].mask, 1'h0);
            check_bit("intReq", ROWS[i].irq, intReq);
            if (ROWS[i].irq) begin
                acknowledge(ROWS[i].vec, ROWS[i].casc);
            end
        end
        // Both side paths get through a full mask
        expansionReq <= 16'h0000;
        channelCheck <= 1'h1;
        smiRequest <= 1'h1;
        configure(16'hFFFF, 1'h0);
        check_bit("nmiOut", 1'h1, nmiOut);
        check_bit("smiOut", 1'h1, smiOut);
        check_bit("intReq", 1'h0, intReq);
        // Legacy line lands on nine; held level repeats the same winner
        channelCheck <= 1'h0;
        smiRequest <= 1'h0;
        legacyBusIrq2 <= 1'h1;
        configure(16'hFDFB, 1'h1);
        check_bit("nmiOut", 1'h0, nmiOut);
        acknowledge(8'h0A, 1'h1);
        acknowledge(8'h0A, 1'h1);
        // Mid-run reset masks every line again while line 9 still pends
        sysRst <= 1'h1;
        repeat (2) @(posedge sysClk);
        sysRst <= 1'h0;
        repeat (8) @(posedge sysClk);
        check_bit("intReq", 1'h0, intReq);
        // Remap comes back off, so line 9 answers at its plain vector
        configure(16'hFDFB, 1'h0);
        check_bit("intReq", 1'h1, intReq);
        acknowledge(8'h71, 1'h1);
        finish_test();
    end
endmodule

// [dv/irq_core_model.sv]
// Processor-side model that acknowledges requests and keeps the answer
`timescale 1ns/1ns
module irq_core_model (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic ackGo,
    input wire irq_pair_pkg::ackResp_t ackResp,
    output logic ackReq,
    output logic [7:0] gotVector,
    output logic gotCascade,
    output logic gotValid
);
    // One-cycle acknowledge per bench request, never stretched
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ackReq <= 1'h0;
        end else begin
            ackReq <= ackGo;
        end
    end
    // Old answer dropped at each acknowledge so a stale one never counts
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            gotValid <= 1'h0;
            gotVector <= 8'h00;
            gotCascade <= 1'h0;
        end else if (ackReq) begin
            gotValid <= 1'h0;
        end else if (ackResp.valid) begin
            gotValid <= 1'h1;
            gotVector <= ackResp.vector;
            gotCascade <= ackResp.cascade;
        end
    end
endmodule
